// *** shared/synth_cfg_map.svh ***
// synth_cfg_map.svh: register selects, field positions, defaults and counts for
// the serially programmed synthesizer configuration block.
// assumes 24-bit words, data in bits 23:4, register select in bits 3:0.
`ifndef SYNTH_CFG_MAP_SVH
`define SYNTH_CFG_MAP_SVH

// register select codes
`define SEL_MODULATOR       4'h3
`define SEL_FASTLOCK        4'h4
`define SEL_POWER           4'h5
`define SEL_LOOP_FILTER     4'h6
`define SEL_CAL_CLOCK       4'h7
`define SEL_CAL_SELECT      4'h8
`define SEL_LOCK_DETECT     4'h9
`define SEL_FIXED_SETUP     4'hC
`define SEL_FIRST_STORED    3
`define SEL_LAST_STORED     9

// word layout
`define WORD_BITS           24
`define SEL_MSB             3

// modulator_config
`define HALVER_BIT          23
`define EXT_FRAC_BIT        22
`define DITHER_MSB          21
`define DITHER_LSB          20
`define ORDER_MSB           19
`define ORDER_LSB           18
`define TESTSEL_MSB         17
`define TESTSEL_LSB         14
`define DEN_UP_MSB          13
`define DEN_UP_LSB          4

// fastlock_timing
`define FPUMP_MSB           21
`define FPUMP_LSB           18
`define TIMEOUT_MSB         17
`define TIMEOUT_LSB         4
`define TIMEOUT_MIN         14'h0004

// power_control
`define SOFT_RST_BIT        19
`define POWER_MSB           10
`define POWER_LSB           4

// loop_filter_config
`define RANGE_MSB           23
`define RANGE_LSB           21
`define FILTER_EN_BIT       16
`define R4_MSB              15
`define R4_LSB              14
`define R4F_MSB             13
`define R4F_LSB             12
`define R3_MSB              11
`define R3_LSB              10
`define R3F_MSB             9
`define R3F_LSB             8
`define CAP_MSB             7
`define CAP_LSB             5

// calibration_clock_config, calibration_select, lock_detect_config
`define CALTIME_MSB         21
`define CALTIME_LSB         10
`define CALDIV_MSB          9
`define CALDIV_LSB          8
`define CALHIGH_BIT         4
`define LD_PRESCALE_BIT     17

// defaults: everything zero, so blocks and regulators come up powered down
`define WORD_DEFAULT        24'h00_0000

// bypass capacitor value in pF when the pole filter is off
`define BYPASS_CAP_PF       8'h64

`endif

// *** shared/synth_cfg_pkg.sv ***
// synth_cfg_pkg: types shared by the configuration block and its users.
// assumes synth_cfg_map.svh holds all numeric layout.
package synth_cfg_pkg;

    typedef enum logic [1:0] {ORDER_FOURTH, ORDER_HOLD, ORDER_SECOND, ORDER_THIRD} mod_order_e;

    typedef enum logic [1:0] {DITHER_WEAK, DITHER_STRONG, DITHER_OFF} dither_e;

    // same bit order as the power word, bit 10 down to bit 4
    typedef struct packed {
        logic digitalReg;
        logic loopRegB;
        logic loopRegA;
        logic oscReg;
        logic refBuffer;
        logic oscillator;
        logic loop;
    } power_s;

    typedef struct packed {
        logic [5:0] thirdKohm;
        logic [5:0] fourthKohm;
        logic [7:0] c3Pf;
        logic [7:0] c4Pf;
    } pole_filter_s;

    typedef struct packed {
        logic [2:0]  rangeSel;
        logic [1:0]  divCode;
        logic [11:0] timing;
        logic        highRef;
    } cal_cfg_s;

endpackage

// *** design/tick_divider.sv ***
// tick_divider: counts single-cycle ticks and emits one tick per modulus+1 inputs.
// assumes tickIn is a one-cycle pulse on ref_clk; level toggles on each output tick.
`timescale 1ns/1ps
module tick_divider #(
    parameter int WIDTH = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             tickIn,
    input  wire logic [WIDTH-1:0] modulus,
    output logic                  tickOut,
    output logic                  level
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic             tick_r;
    logic             tick_nxt;
    logic             level_r;
    logic             level_nxt;

    if (WIDTH < 1) begin : g_chk
        $error("tick_divider WIDTH must be at least 1");
    end

    always_comb begin
        count_nxt = count_r;
        tick_nxt  = 1'b0;
        level_nxt = level_r;
        if (tickIn) begin
            // modulus change mid-count: wrap on >= so it never runs away
            if (count_r >= modulus) begin
                count_nxt = '0;
                tick_nxt  = 1'b1;
                level_nxt = ~level_r;
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_r <= '0;
            tick_r  <= 1'b0;
            level_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r  <= tick_nxt;
            level_r <= level_nxt;
        end
    end

    assign tickOut = tick_r;
    assign level   = level_r;
endmodule // tick_divider

// *** design/synth_config_regs.sv ***
// synth_config_regs: serial write-only configuration registers and their field logic.
// assumes pins arrive asynchronous to ref_clk; pump code, numerator bits and fastLockStart
// come from the counter register logic on ref_clk.
`timescale 1ns/1ps
`include "synth_cfg_map.svh"
module synth_config_regs #(
    parameter bit HALVER_SUPPORTED = 1'b1,
    parameter int TIMEOUT_WIDTH    = 14
) (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        serClk,
    input  wire logic                        serData,
    input  wire logic                        latch_strobe,
    input  wire logic                        reference_input,
    input  wire logic                        pdClkPin,
    input  wire logic                        fbCounterPin,
    input  wire logic                        digLockIn,
    input  wire logic                        anaLockIn,
    input  wire logic [3:0]                  pump_current_code,
    input  wire logic [9:0]                  numUpperIn,
    input  wire logic                        fastLockStart,
    output logic                             testLockOut,
    output logic                             testLockOe,
    output logic                             fastAssistOut,
    output logic                             fastAssistOe,
    output synth_cfg_pkg::mod_order_e        modOrder,
    output synth_cfg_pkg::dither_e           ditherMode,
    output logic                             extended_fraction_mode,
    output logic [9:0]                       numUpperEff,
    output logic [9:0]                       denUpperEff,
    output logic                             oscOutHalve,
    output logic [3:0]                       pumpCurrentEff,
    output logic                             fastLockActive,
    output synth_cfg_pkg::power_s            powerEn,
    output synth_cfg_pkg::pole_filter_s      poleFilter,
    output synth_cfg_pkg::cal_cfg_s          calCfg,
    output logic                             calClkTick,
    output logic                             lockCompareTick
);
    localparam int NPIN = 6;

    if (TIMEOUT_WIDTH != 14) begin : g_chk
        $error("field layout serves a 14-bit timeout only");
    end

    // pin synchronisers; stage one feeds stage two only
    logic [NPIN-1:0] pinMeta_r;
    logic [NPIN-1:0] pinSync_r;
    logic [NPIN-1:0] pinPrev_r;
    logic [NPIN-1:0] pinRise;
    logic [1:0]      lockMeta_r;
    logic [1:0]      lockSync_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pinMeta_r  <= '0;
            pinSync_r  <= '0;
            pinPrev_r  <= '0;
            lockMeta_r <= '0;
            lockSync_r <= '0;
        end else begin
            pinMeta_r  <= {fbCounterPin, pdClkPin, reference_input,
                           latch_strobe, serData, serClk};
            pinSync_r  <= pinMeta_r;
            pinPrev_r  <= pinSync_r;
            lockMeta_r <= {anaLockIn, digLockIn};
            lockSync_r <= lockMeta_r;
        end
    end
    assign pinRise = pinSync_r & ~pinPrev_r;

    // serial shift and register store
    logic [`WORD_BITS-1:0] shift_r;
    logic [`WORD_BITS-1:0] shift_nxt;
    logic [`WORD_BITS-1:0] cfgWord_r   [`SEL_FIRST_STORED:`SEL_LAST_STORED];
    logic [`WORD_BITS-1:0] cfgWord_nxt [`SEL_FIRST_STORED:`SEL_LAST_STORED];
    logic [`SEL_MSB:0]     wordSel;
    logic                  latchEvt;
    logic                  softRstWrite;
    logic                  softRstHeld;

    assign latchEvt     = pinRise[2];
    assign wordSel      = shift_r[`SEL_MSB:0];
    assign softRstWrite = latchEvt && wordSel == `SEL_POWER && shift_r[`SOFT_RST_BIT];
    assign softRstHeld  = cfgWord_r[5][`SOFT_RST_BIT];

    always_comb begin
        shift_nxt = shift_r;
        if (pinRise[0]) begin
            shift_nxt = {shift_r[`WORD_BITS-2:0], pinSync_r[1]};
        end
        for (int i = `SEL_FIRST_STORED; i <= `SEL_LAST_STORED; i++) begin
            cfgWord_nxt[i] = cfgWord_r[i];
        end
        // soft reset loads defaults and keeps them while set
        if (softRstWrite) begin
            for (int i = `SEL_FIRST_STORED; i <= `SEL_LAST_STORED; i++) begin
                cfgWord_nxt[i] = `WORD_DEFAULT;
            end
            cfgWord_nxt[5] = shift_r;
        // register select decode on strobe rise
        end else if (latchEvt && wordSel == `SEL_POWER) begin
            cfgWord_nxt[5] = shift_r;
        // other codes and held reset leave the store alone
        end else if (latchEvt && !softRstHeld && wordSel >= 4'(`SEL_FIRST_STORED)
                     && wordSel <= 4'(`SEL_LAST_STORED)) begin
            cfgWord_nxt[wordSel] = shift_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shift_r <= '0;
            for (int i = `SEL_FIRST_STORED; i <= `SEL_LAST_STORED; i++) begin
                cfgWord_r[i] <= `WORD_DEFAULT;
            end
        end else begin
            shift_r <= shift_nxt;
            for (int i = `SEL_FIRST_STORED; i <= `SEL_LAST_STORED; i++) begin
                cfgWord_r[i] <= cfgWord_nxt[i];
            end
        end
    end

    // field views
    logic [3:0]  testSel;
    logic [13:0] timeout;
    logic [3:0]  fastPump;
    logic [1:0]  ditherCode;
    assign testSel    = cfgWord_r[3][`TESTSEL_MSB:`TESTSEL_LSB];
    assign ditherCode = cfgWord_r[3][`DITHER_MSB:`DITHER_LSB];
    assign timeout    = cfgWord_r[4][`TIMEOUT_MSB:`TIMEOUT_LSB];
    assign fastPump   = cfgWord_r[4][`FPUMP_MSB:`FPUMP_LSB];

    // order code maps straight onto the enum
    assign modOrder = synth_cfg_pkg::mod_order_e'(cfgWord_r[3][`ORDER_MSB:`ORDER_LSB]);

    // reserved dither code treated as off, never an undefined mode
    always_comb begin
        case (ditherCode)
            2'h0:    ditherMode = synth_cfg_pkg::DITHER_WEAK;
            2'h2:    ditherMode = synth_cfg_pkg::DITHER_STRONG;
            default: ditherMode = synth_cfg_pkg::DITHER_OFF;
        endcase
    end

    // upper fraction bits masked unless extended mode
    assign extended_fraction_mode = cfgWord_r[3][`EXT_FRAC_BIT];
    assign numUpperEff = extended_fraction_mode ? numUpperIn : 10'h000;
    assign denUpperEff = extended_fraction_mode ? cfgWord_r[3][`DEN_UP_MSB:`DEN_UP_LSB] : 10'h000;

    // halver only where the variant has one
    assign oscOutHalve = HALVER_SUPPORTED & cfgWord_r[3][`HALVER_BIT];

    // block enables, regulators and reference buffer
    assign powerEn = softRstHeld ? '0 : cfgWord_r[5][`POWER_MSB:`POWER_LSB];

    // fast-lock timeout, counted in detector edges
    logic [TIMEOUT_WIDTH:0] fastCnt_r;
    logic [TIMEOUT_WIDTH:0] fastCnt_nxt;
    logic                   timeoutEngaged;
    assign timeoutEngaged = timeout >= `TIMEOUT_MIN;

    always_comb begin
        fastCnt_nxt = fastCnt_r;
        if (softRstHeld || !timeoutEngaged) begin
            fastCnt_nxt = '0;
        // load value times two detector cycles
        end else if (fastLockStart) begin
            fastCnt_nxt = {timeout, 1'b0};
        end else if (pinRise[4] && fastCnt_r != '0) begin
            fastCnt_nxt = fastCnt_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fastCnt_r <= '0;
        end else begin
            fastCnt_r <= fastCnt_nxt;
        end
    end

    // code 1 keeps fast-lock on permanently
    assign fastLockActive = (fastCnt_r != '0) || timeout == 14'h0001;

    assign pumpCurrentEff = fastLockActive ? fastPump : pump_current_code;

    // loop filter selections
    function automatic logic [5:0] kohm(input logic [1:0] code);
        case (code)
            2'h0:    kohm = 6'h0A;
            2'h1:    kohm = 6'h14;
            2'h2:    kohm = 6'h1E;
            default: kohm = 6'h28;
        endcase
    endfunction

    function automatic logic [15:0] capPair(input logic [2:0] code);
        case (code)
            3'h0:    capPair = {8'h32, 8'h32};
            3'h1:    capPair = {8'h32, 8'h64};
            3'h2:    capPair = {8'h32, 8'h96};
            3'h3:    capPair = {8'h64, 8'h32};
            3'h4:    capPair = {8'h96, 8'h32};
            3'h5:    capPair = {8'h64, 8'h64};
            default: capPair = {8'h32, 8'h96};
        endcase
    endfunction

    logic [23:0] w6;
    assign w6 = cfgWord_r[6];
    always_comb begin
        poleFilter.thirdKohm  = kohm(fastLockActive ? w6[`R3F_MSB:`R3F_LSB] : w6[`R3_MSB:`R3_LSB]);
        poleFilter.fourthKohm = kohm(fastLockActive ? w6[`R4F_MSB:`R4F_LSB] : w6[`R4_MSB:`R4_LSB]);
        {poleFilter.c3Pf, poleFilter.c4Pf} = capPair(w6[`CAP_MSB:`CAP_LSB]);
        // bypass the third and fourth poles
        if (!w6[`FILTER_EN_BIT]) begin
            poleFilter.thirdKohm  = 6'h00;
            poleFilter.fourthKohm = 6'h00;
            poleFilter.c3Pf       = `BYPASS_CAP_PF;
            poleFilter.c4Pf       = `BYPASS_CAP_PF;
        end
    end

    // calibration settings and clocks
    assign calCfg.rangeSel = w6[`RANGE_MSB:`RANGE_LSB];
    assign calCfg.divCode  = cfgWord_r[7][`CALDIV_MSB:`CALDIV_LSB];
    assign calCfg.timing   = cfgWord_r[7][`CALTIME_MSB:`CALTIME_LSB];
    assign calCfg.highRef  = cfgWord_r[8][`CALHIGH_BIT];

    logic [2:0] calModulus;
    logic       ldPrescale;
    logic       ldDivTick;
    logic       fbHalfLevel;
    // divide by 2, 4, 8; reserved code stops the clock
    assign calModulus = (3'h1 << calCfg.divCode) - 3'h1;
    assign ldPrescale = cfgWord_r[9][`LD_PRESCALE_BIT];

    tick_divider #(.WIDTH(3)) u_cal_div (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tickIn  (pinRise[3] && calCfg.divCode != 2'h0),
        .modulus (calModulus),
        .tickOut (calClkTick),
        .level   ()
    );

    // comparison ticks divided by four for lock detect
    tick_divider #(.WIDTH(2)) u_ld_div (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tickIn  (pinRise[4]),
        .modulus (2'h3),
        .tickOut (ldDivTick),
        .level   ()
    );
    assign lockCompareTick = ldPrescale ? ldDivTick : pinRise[4];

    tick_divider #(.WIDTH(1)) u_fb_half (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tickIn  (pinRise[5]),
        .modulus (1'b0),
        .tickOut (),
        .level   (fbHalfLevel)
    );

    // pin drivers, registered so the pads see clean levels
    logic testOut_nxt;
    logic testOe_nxt;
    logic fastOut_nxt;
    logic fastOe_nxt;
    always_comb begin
        testOut_nxt = 1'b0;
        testOe_nxt  = 1'b1;
        case (testSel)
            4'h1:    testOut_nxt = 1'b1;
            4'h2:    testOut_nxt = 1'b0;
            4'h3:    testOut_nxt = lockSync_r[0];
            4'h5:    testOut_nxt = fbHalfLevel;
            4'h6:    testOe_nxt  = ~lockSync_r[1];
            4'h7:    testOut_nxt = lockSync_r[1];
            default: testOe_nxt  = 1'b0;
        endcase
        fastOut_nxt = 1'b0;
        fastOe_nxt  = 1'b1;
        case (timeout)
            14'h0000: fastOe_nxt  = 1'b0;
            14'h0003: fastOut_nxt = 1'b1;
            14'h0001: fastOe_nxt  = 1'b1;
            14'h0002: fastOe_nxt  = 1'b1;
            default:  fastOe_nxt  = fastLockActive;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            testLockOut   <= 1'b0;
            testLockOe    <= 1'b0;
            fastAssistOut <= 1'b0;
            fastAssistOe  <= 1'b0;
        end else begin
            testLockOut   <= testOut_nxt;
            testLockOe    <= testOe_nxt;
            fastAssistOut <= fastOut_nxt;
            fastAssistOe  <= fastOe_nxt;
        end
    end

    // checks
    a_order_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        latchEvt && wordSel == `SEL_MODULATOR && !softRstHeld
        && shift_r[`ORDER_MSB:`ORDER_LSB] == 2'h1 |=> modOrder == synth_cfg_pkg::ORDER_HOLD)
        else $error("order code 1 did not hold the modulator");
    a_dither_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
        latchEvt && wordSel == `SEL_MODULATOR && !softRstHeld
        && shift_r[`DITHER_MSB:`DITHER_LSB] == 2'h3 |=> ditherMode == synth_cfg_pkg::DITHER_OFF)
        else $error("dither code 3 did not disable dithering");
    a_frac_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !extended_fraction_mode |-> numUpperEff == 10'h000 && denUpperEff == 10'h000)
        else $error("upper fraction bits leaked without extended mode");
    a_test_lock_out_select_drain: assert property (@(posedge ref_clk) disable iff (sys_rst)
        testSel == 4'h6 && $stable(testSel) |=> !testLockOut)
        else $error("open-drain lock output drove high");
    a_fast_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
        fastLockStart && timeoutEngaged && !softRstHeld |=> fastCnt_r == {$past(timeout), 1'b0})
        else $error("timeout count not loaded as twice the value");
    a_fast_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
        fastLockActive && timeoutEngaged ##1 timeoutEngaged |-> fastAssistOe && !fastAssistOut)
        else $error("fast assist pin not grounded during fast-lock");
    a_pump_swap: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !fastLockActive |-> pumpCurrentEff == pump_current_code)
        else $error("fast pump code used outside fast-lock");
    a_soft_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
        softRstWrite |=> powerEn == '0 && modOrder == synth_cfg_pkg::ORDER_FOURTH)
        else $error("soft reset left power or config set");
    a_pole_bypass: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !w6[`FILTER_EN_BIT] |-> poleFilter.thirdKohm == 6'h00 && poleFilter.c4Pf == 8'h64)
        else $error("pole filter not bypassed");
    a_unmapped_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
        latchEvt && wordSel inside {4'hA, 4'hB, 4'hD, 4'hE, 4'hF} |=> $stable(powerEn)
        && $stable(modOrder) && $stable(calCfg))
        else $error("unused select changed stored state");
endmodule // synth_config_regs

// *** dv/serial_host.sv ***
// serial_host: host side of the three-wire write-only port.
// assumes ref_clk comes from the bench; pins change just after its rising edge.
`timescale 1ns/1ps
module serial_host (
    input  wire logic ref_clk,
    output logic      serClk,
    output logic      serData,
    output logic      latch_strobe
);
    initial begin
        serClk = 1'b0;
        serData = 1'b0;
        latch_strobe = 1'b0;
    end
    task automatic send(input logic [23:0] word);
        // start on an edge so every pin change lands on one
        @(posedge ref_clk);
        for (int i = 23; i >= 0; i--) begin
            serData <= word[i];
            repeat (4) @(posedge ref_clk);
            serClk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            serClk <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        latch_strobe <= 1'b1;
        repeat (4) @(posedge ref_clk);
        latch_strobe <= 1'b0;
        // released line must not echo the last bit
        serData <= ~word[0];
        repeat (8) @(posedge ref_clk);
    endtask
endmodule // serial_host

// *** dv/tb.sv ***
// tb: write sequences through the serial port, field outputs compared.
// assumes the serial_host model; lock, reference and feedback pins come from the bench.
`timescale 1ns/1ps
module tb;
    logic ref_clk, sys_rst, serClk, serData, latch_strobe, pdClkPin, fastLockStart;
    logic testLockOut, testLockOe, fastAssistOut, fastAssistOe, extMode, halve;
    logic fastActive, calTick, lockTick, refPin, fbPin, digLock, anaLock;
    logic [3:0] pumpCode, pumpEff;
    logic [9:0] numUpperIn, numEff, denEff;
    synth_cfg_pkg::mod_order_e modOrder;
    synth_cfg_pkg::dither_e ditherMode;
    synth_cfg_pkg::power_s powerEn;
    synth_cfg_pkg::pole_filter_s poleFilter;
    synth_cfg_pkg::cal_cfg_s calCfg;
    synth_cfg_pkg::dither_e dith [4] = '{synth_cfg_pkg::DITHER_WEAK, synth_cfg_pkg::DITHER_OFF,
        synth_cfg_pkg::DITHER_STRONG, synth_cfg_pkg::DITHER_OFF};
    int bad_count = 0;
    int checks = 0;
    int calCount = 0;
    int lockCount = 0;
    int c0;

    always @(posedge ref_clk) begin
        if (calTick) calCount <= calCount + 1;
        if (lockTick) lockCount <= lockCount + 1;
    end

    serial_host u_host (.ref_clk(ref_clk), .serClk(serClk), .serData(serData),
        .latch_strobe(latch_strobe));
    synth_config_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .serClk(serClk),
        .serData(serData), .latch_strobe(latch_strobe), .reference_input(refPin),
        .pdClkPin(pdClkPin), .fbCounterPin(fbPin), .digLockIn(digLock), .anaLockIn(anaLock),
        .pump_current_code(pumpCode), .numUpperIn(numUpperIn), .fastLockStart(fastLockStart),
        .testLockOut(testLockOut), .testLockOe(testLockOe), .fastAssistOut(fastAssistOut),
        .fastAssistOe(fastAssistOe), .modOrder(modOrder), .ditherMode(ditherMode),
        .extended_fraction_mode(extMode), .numUpperEff(numEff), .denUpperEff(denEff),
        .oscOutHalve(halve), .pumpCurrentEff(pumpEff), .fastLockActive(fastActive),
        .powerEn(powerEn), .poleFilter(poleFilter), .calCfg(calCfg), .calClkTick(calTick),
        .lockCompareTick(lockTick));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        #1;
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // pins in which: fb, pd, ref; each pulse is high 4 cycles, low 6 before the next
    task automatic pulse_pins(input logic [2:0] which, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge ref_clk);
            {fbPin, pdClkPin, refPin} <= which;
            repeat (4) @(posedge ref_clk);
            {fbPin, pdClkPin, refPin} <= 3'b000;
            repeat (5) @(posedge ref_clk);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        sys_rst = 1'b1;
        {refPin, fbPin, digLock, anaLock} = 4'h0;
        pdClkPin = 1'b0;
        fastLockStart = 1'b0;
        pumpCode = 4'h3;
        numUpperIn = 10'h2AA;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk(powerEn, 32'h0000_0000);
        chk(poleFilter, {6'h00, 6'h00, 8'h64, 8'h64});
        // host init: reset, release, enables
        u_host.send(24'h08_0005);
        u_host.send(24'h00_0005);
        u_host.send(24'h00_07F5);
        chk(powerEn, 7'h7F);
        for (int i = 0; i < 4; i++) begin
            u_host.send(24'(24'hC0_3FF3 | (i << 18) | (i << 20)));
            chk(modOrder, i);
            chk(ditherMode, dith[i]);
        end
        chk({halve, extMode, numEff, denEff}, {2'b11, 10'h2AA, 10'h3FF});
        u_host.send(24'h0D_8003);
        chk({halve, extMode, numEff, denEff}, 22'h00_0000);
        chk({testLockOe, testLockOut}, 2'b10);
        @(posedge ref_clk);
        anaLock <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({testLockOe, testLockOut}, 2'b00);
        u_host.send(24'h0D_C003);
        chk({testLockOe, testLockOut}, 2'b11);
        u_host.send(24'h0C_C003);
        chk({testLockOe, testLockOut}, 2'b10);
        @(posedge ref_clk);
        digLock <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({testLockOe, testLockOut}, 2'b11);
        u_host.send(24'h0D_4003);
        chk({testLockOe, testLockOut}, 2'b10);
        pulse_pins(3'b100, 1);
        chk({testLockOe, testLockOut}, 2'b11);
        pulse_pins(3'b100, 1);
        chk({testLockOe, testLockOut}, 2'b10);
        u_host.send(24'h81_C6A6);
        chk(poleFilter, {6'h14, 6'h28, 8'h64, 8'h64});
        u_host.send(24'h00_0018);
        u_host.send(24'h00_0107);
        chk(calCfg, {3'h4, 2'h1, 12'h000, 1'b1});
        c0 = calCount;
        pulse_pins(3'b001, 8);
        chk(calCount - c0, 32'd4);
        u_host.send(24'h00_0307);
        c0 = calCount;
        pulse_pins(3'b001, 8);
        chk(calCount - c0, 32'd1);
        u_host.send(24'h28_0044);
        fastLockStart <= 1'b1;
        @(posedge ref_clk);
        fastLockStart <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({fastActive, pumpEff, fastAssistOe, fastAssistOut}, 7'b1_1010_10);
        chk(poleFilter[27:16], {6'h1E, 6'h0A});
        c0 = lockCount;
        for (int i = 0; i < 8; i++) begin
            pulse_pins(3'b010, 1);
            if (i >= 6) chk(fastActive, 32'(i == 6));
        end
        chk(lockCount - c0, 32'd8);
        chk({pumpEff, fastAssistOe}, 5'b0011_0);
        u_host.send(24'h00_0034);
        chk({fastAssistOe, fastAssistOut}, 2'b11);
        u_host.send(24'h00_0014);
        chk({fastActive, pumpEff, fastAssistOe, fastAssistOut}, 7'b1_0000_10);
        u_host.send(24'h00_0024);
        chk({fastActive, fastAssistOe, fastAssistOut}, 3'b010);
        u_host.send(24'h00_0004);
        chk({fastActive, fastAssistOe}, 2'b00);
        u_host.send(24'h02_0009);
        c0 = lockCount;
        pulse_pins(3'b010, 8);
        chk(lockCount - c0, 32'd2);
        u_host.send(24'h01_048C);
        u_host.send(24'hFF_FFFA);
        chk({modOrder, powerEn}, {2'h3, 7'h7F});
        u_host.send(24'h08_0005);
        chk({modOrder, powerEn}, 9'h000);
        chk(poleFilter, {6'h00, 6'h00, 8'h64, 8'h64});
        chk(calCfg, 18'h0_0000);
        report_and_stop();
    end
endmodule // tb
